// File: inc/elrsb_pkg.sv
// Package with constants and carriers for the link and ring attribute bank.
package elrsb_pkg;
    // Object class codes and service codes.
    localparam logic [7:0] CLS_PORT      = 8'hf6;
    localparam logic [7:0] CLS_RING      = 8'h47;
    localparam logic [7:0] SVC_GET_ALL   = 8'h01;
    localparam logic [7:0] SVC_GET_ONE   = 8'h0e;
    localparam logic [7:0] SVC_SET_ONE   = 8'h10;
    localparam logic [7:0] SVC_CLR_RAPID = 8'h4c;
    // Port attribute numbers.
    localparam logic [7:0] ATT_FLAGS = 8'h02;
    localparam logic [7:0] ATT_CTRL  = 8'h06;
    localparam logic [7:0] ATT_TYPE  = 8'h07;
    localparam logic [7:0] ATT_STATE = 8'h08;
    localparam logic [7:0] ATT_ADMIN = 8'h09;
    localparam logic [7:0] ATT_LABEL = 8'h0a;
    localparam logic [7:0] ATT_CAPS  = 8'h0b;
    // Ring attribute numbers.
    localparam logic [7:0] ATT_REV  = 8'h01;
    localparam logic [7:0] ATT_TOPO = 8'h01;
    localparam logic [7:0] ATT_NET  = 8'h02;
    // Answer status codes.
    localparam logic [7:0] ST_OK       = 8'h00;
    localparam logic [7:0] ST_NO_DEST  = 8'h05;
    localparam logic [7:0] ST_NO_SVC   = 8'h08;
    localparam logic [7:0] ST_BAD_VAL  = 8'h09;
    localparam logic [7:0] ST_CONFLICT = 8'h0c;
    localparam logic [7:0] ST_RO_ATT   = 8'h0e;
    localparam logic [7:0] ST_NO_ATT   = 8'h14;
    // Field positions and values.
    localparam int         CTL_AUTONEG = 0;
    localparam int         CTL_DUPLEX  = 1;
    localparam int         FLG_RESET   = 5;
    localparam logic [15:0] CTL_USED   = 16'h0003;
    localparam logic [7:0] MED_TP      = 8'h02;
    localparam logic [7:0] MED_INT     = 8'h01;
    localparam logic [7:0] OPS_UNKNOWN = 8'h00;
    localparam logic [7:0] OPS_UP      = 8'h01;
    localparam logic [7:0] OPS_DOWN    = 8'h02;
    localparam logic [7:0] ADM_ON      = 8'h01;
    localparam logic [7:0] ADM_OFF     = 8'h02;
    localparam logic [15:0] RING_REV   = 16'h0003;
    localparam logic [7:0] NET_NORMAL  = 8'h00;
    localparam logic [7:0] NET_RFAULT  = 8'h01;
    localparam logic [7:0] NET_LOOP    = 8'h02;
    localparam logic [7:0] NET_PARTIAL = 8'h03;
    localparam logic [7:0] NET_RAPID   = 8'h04;
    // Reset values and the device's fixed choice on reset-to-apply.
    localparam logic [15:0] RST_SPEED  = 16'h000a;
    localparam logic        CAP_RST_REQ = 1'b0;
    // Labels: length byte in the low byte, characters above it.
    localparam logic [71:0] LBL_P1  = 72'h00_0031_2074_726f_5006;
    localparam logic [71:0] LBL_P2  = 72'h00_0032_2074_726f_5006;
    localparam logic [71:0] LBL_INT = 72'h6c_616e_7265_746e_4908;
    // Service request and answer carriers.
    typedef struct packed {
        logic [7:0]  svc;
        logic [7:0]  cls;
        logic [7:0]  inst;
        logic [7:0]  att;
        logic [31:0] wdata;
    } elrsb_req_t;
    typedef struct packed {
        logic [7:0]  status;
        logic [71:0] data;
    } elrsb_rsp_t;
endpackage

// File: hw/elrsb_bank.sv
// Attribute bank for Ethernet port settings and ring redundancy status.
`timescale 1ns/1ps
// Function
// - With negotiation off, the port runs at the forced speed in Mbps; the internal port keeps port_speed_r at 0.
// - Medium type reads 2 for ports one and two, 1 for the third.
// - Operational state codes: 0 unknown, 1 up, 2 down.
// - Admin writes of 1 enable and 2 disable; other values are refused.
// - Each instance returns its own short label string.
// - Capability bit 0 says whether control changes need a reset.
// - Ports without control settings report capability bit 0 as zero.
// - Capability bit 0 is copied into flags bit 5.
// - Capability bit 1 marks negotiation support on external ports only.
// - Capability bit 2 marks crossover detection on external ports only.
// - Capability bit 3 marks manual speed support; without it control is refused.
// - Capability bits 4 to 31 read as zero.
// - Ring object revision reads 0003h.
// - Ring class takes read-all and read-one; instance takes read-one and the clear service.
// - Topology reads 0 for linear and 1 for ring.
// - Network status reads 0 in normal operation.
// - Ring fault is reported only in ring topology.
// - Unexpected loop is reported only in linear topology.
// - Partial fault needs ring topology and active supervisor.
// - Rapid fault cycles block ring forwarding until the clear service.
// - Control bit 0 enables negotiation; else forced duplex and speed apply; the internal port's speed output stays 0.
// - Flags bit 5 reads 1 when a reset is needed for link changes.
module elrsb_bank (
    // Clock and reset.
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    // Attribute service request.
    input  wire logic                  req_valid,
    input  wire elrsb_pkg::elrsb_req_t req,
    // Attribute service answer.
    output logic                       rsp_valid_r,
    output elrsb_pkg::elrsb_rsp_t      rsp_r,
    // Ring protocol status from the ring engine.
    input  wire logic                  ring_mode_in,
    input  wire logic                  supervisor_in,
    input  wire logic                  ring_fault_in,
    input  wire logic                  loop_seen_in,
    input  wire logic                  partial_fault_in,
    input  wire logic                  rapid_cycle_evt,
    // Port settings applied to the link logic.
    output logic [2:0]                 port_enable_r,
    output logic [2:0]                 port_autoneg_r,
    output logic [2:0]                 port_full_duplex_r,
    output logic [2:0][15:0]           port_speed_r,
    // Ring status results.
    output logic                       ring_topo_r,
    output logic [7:0]                 net_status_r,
    output logic                       block_ring_fwd_r
);
    logic [2:0][7:0]  admin_r;
    logic [2:0][15:0] ctrl_r;
    logic [2:0][15:0] speed_r;
    logic             rapid_r;
    logic [2:0]       wr_ctrl;
    logic [2:0]       wr_admin;
    elrsb_pkg::elrsb_rsp_t rsp_nxt;
    logic [7:0]       net_nxt;

    // Request decode.
    wire        is_get    = req.svc == elrsb_pkg::SVC_GET_ONE;
    wire        is_set    = req.svc == elrsb_pkg::SVC_SET_ONE;
    wire        is_all    = req.svc == elrsb_pkg::SVC_GET_ALL;
    wire        is_clr    = req.svc == elrsb_pkg::SVC_CLR_RAPID;
    wire        cls_port  = req.cls == elrsb_pkg::CLS_PORT;
    wire        cls_ring  = req.cls == elrsb_pkg::CLS_RING;
    wire        inst_ok   = (req.inst >= 8'h01) && (req.inst <= 8'h03);
    wire [1:0]  pidx      = 2'(req.inst - 8'h01);
    wire        ext_port  = pidx != 2'd2;
    wire [15:0] w_ctrl    = req.wdata[15:0];
    wire [15:0] w_speed   = req.wdata[31:16];
    wire [7:0]  w_admin   = req.wdata[7:0];

    // Capability word per selected port, reserved bits zero.
    wire [31:0] caps = {28'h0000000,
                        ext_port,
                        ext_port,
                        ext_port,
                        ext_port & elrsb_pkg::CAP_RST_REQ};

    // Validity of a control write; the internal port has no control settings.
    wire ctl_bad_bits = (w_ctrl & ~elrsb_pkg::CTL_USED) != 16'h0000;
    wire ctl_bad_spd  = !w_ctrl[elrsb_pkg::CTL_AUTONEG] &&
                        (w_speed != 16'd10) && (w_speed != 16'd100);
    wire ctl_conflict = w_ctrl[elrsb_pkg::CTL_AUTONEG] &&
                        w_ctrl[elrsb_pkg::CTL_DUPLEX];
    wire adm_ok       = (w_admin == elrsb_pkg::ADM_ON) ||
                        (w_admin == elrsb_pkg::ADM_OFF);
    wire port_set     = req_valid && cls_port && inst_ok && is_set;
    wire ctl_ok       = caps[3] && !ctl_bad_bits && !ctl_bad_spd && !ctl_conflict;

    // Clear-rapid-faults service on the ring instance.
    wire clr_rapid = req_valid && cls_ring && is_clr && (req.inst == 8'h01);

    // Answer building for every accepted or refused service.
    always_comb begin
        rsp_nxt = '0;
        rsp_nxt.status = elrsb_pkg::ST_OK;
        if (cls_port) begin
            if (!inst_ok) begin
                rsp_nxt.status = elrsb_pkg::ST_NO_DEST;
            end else if (is_get) begin
                unique case (req.att)
                    elrsb_pkg::ATT_FLAGS: begin
                        rsp_nxt.data[elrsb_pkg::FLG_RESET] = caps[0];
                    end
                    elrsb_pkg::ATT_CTRL: begin
                        if (caps[3]) begin
                            rsp_nxt.data[31:0] = {speed_r[pidx], ctrl_r[pidx]};
                        end else begin
                            rsp_nxt.status = elrsb_pkg::ST_NO_ATT;
                        end
                    end
                    elrsb_pkg::ATT_TYPE: begin
                        rsp_nxt.data[7:0] = ext_port ? elrsb_pkg::MED_TP
                                                     : elrsb_pkg::MED_INT;
                    end
                    elrsb_pkg::ATT_STATE: begin
                        rsp_nxt.data[7:0] = port_enable_r[pidx] ? elrsb_pkg::OPS_UP
                                                                : elrsb_pkg::OPS_DOWN;
                    end
                    elrsb_pkg::ATT_ADMIN: begin
                        rsp_nxt.data[7:0] = admin_r[pidx];
                    end
                    elrsb_pkg::ATT_LABEL: begin
                        rsp_nxt.data = (pidx == 2'd0) ? elrsb_pkg::LBL_P1 :
                                       (pidx == 2'd1) ? elrsb_pkg::LBL_P2 :
                                                        elrsb_pkg::LBL_INT;
                    end
                    elrsb_pkg::ATT_CAPS: begin
                        rsp_nxt.data[31:0] = caps;
                    end
                    default: begin
                        rsp_nxt.status = elrsb_pkg::ST_NO_ATT;
                    end
                endcase
            end else if (is_set) begin
                if (req.att == elrsb_pkg::ATT_ADMIN) begin
                    rsp_nxt.status = adm_ok ? elrsb_pkg::ST_OK
                                            : elrsb_pkg::ST_BAD_VAL;
                end else if (req.att == elrsb_pkg::ATT_CTRL) begin
                    if (!caps[3]) begin
                        rsp_nxt.status = elrsb_pkg::ST_NO_ATT;
                    end else if (ctl_conflict) begin
                        rsp_nxt.status = elrsb_pkg::ST_CONFLICT;
                    end else if (ctl_bad_bits || ctl_bad_spd) begin
                        rsp_nxt.status = elrsb_pkg::ST_BAD_VAL;
                    end
                end else begin
                    rsp_nxt.status = elrsb_pkg::ST_RO_ATT;
                end
            end else begin
                rsp_nxt.status = elrsb_pkg::ST_NO_SVC;
            end
        end else if (cls_ring) begin
            if (req.inst == 8'h00) begin
                if (is_all) begin
                    rsp_nxt.data[15:0] = elrsb_pkg::RING_REV;
                end else if (is_get && req.att == elrsb_pkg::ATT_REV) begin
                    rsp_nxt.data[15:0] = elrsb_pkg::RING_REV;
                end else if (is_get) begin
                    rsp_nxt.status = elrsb_pkg::ST_NO_ATT;
                end else begin
                    rsp_nxt.status = elrsb_pkg::ST_NO_SVC;
                end
            end else if (req.inst == 8'h01) begin
                if (is_get && req.att == elrsb_pkg::ATT_TOPO) begin
                    rsp_nxt.data[0] = ring_topo_r;
                end else if (is_get && req.att == elrsb_pkg::ATT_NET) begin
                    rsp_nxt.data[7:0] = net_status_r;
                end else if (is_get) begin
                    rsp_nxt.status = elrsb_pkg::ST_NO_ATT;
                end else if (!is_clr) begin
                    rsp_nxt.status = elrsb_pkg::ST_NO_SVC;
                end
            end else begin
                rsp_nxt.status = elrsb_pkg::ST_NO_DEST;
            end
        end else begin
            rsp_nxt.status = elrsb_pkg::ST_NO_DEST;
        end
    end

    // Answer register: one answer per request, one cycle later.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rsp_valid_r <= 1'b0;
            rsp_r       <= '0;
        end else begin
            rsp_valid_r <= req_valid;
            if (req_valid) begin
                rsp_r <= rsp_nxt;
            end
        end
    end

    // Per-port settings; a refused write leaves every setting untouched.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_port
            assign wr_admin[gi] = port_set && (pidx == 2'(gi)) &&
                                  (req.att == elrsb_pkg::ATT_ADMIN) && adm_ok;
            assign wr_ctrl[gi]  = port_set && (pidx == 2'(gi)) &&
                                  (req.att == elrsb_pkg::ATT_CTRL) && ctl_ok;
            // Settings and the values driven to the link logic.
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    admin_r[gi]            <= elrsb_pkg::ADM_ON;
                    ctrl_r[gi]             <= (gi < 2) ? 16'h0001 : 16'h0000;
                    speed_r[gi]            <= elrsb_pkg::RST_SPEED;
                    port_enable_r[gi]      <= 1'b1;
                    port_autoneg_r[gi]     <= (gi < 2);
                    port_full_duplex_r[gi] <= 1'b0;
                    port_speed_r[gi]       <= 16'h0000;
                end else begin
                    if (wr_admin[gi]) begin
                        admin_r[gi]       <= w_admin;
                        port_enable_r[gi] <= (w_admin == elrsb_pkg::ADM_ON);
                    end
                    if (wr_ctrl[gi]) begin
                        ctrl_r[gi]  <= w_ctrl;
                        speed_r[gi] <= w_speed;
                        port_autoneg_r[gi] <= w_ctrl[elrsb_pkg::CTL_AUTONEG];
                        port_full_duplex_r[gi] <= !w_ctrl[elrsb_pkg::CTL_AUTONEG] &&
                                                  w_ctrl[elrsb_pkg::CTL_DUPLEX];
                        port_speed_r[gi] <= w_ctrl[elrsb_pkg::CTL_AUTONEG] ?
                                            16'h0000 : w_speed;
                    end
                end
            end
        end
    endgenerate

    // Network status code from the ring engine's view, gated by topology.
    assign net_nxt =
        (ring_mode_in && rapid_r && supervisor_in)          ? elrsb_pkg::NET_RAPID   :
        (ring_mode_in && partial_fault_in && supervisor_in) ? elrsb_pkg::NET_PARTIAL :
        (ring_mode_in && ring_fault_in)                     ? elrsb_pkg::NET_RFAULT  :
        (!ring_mode_in && loop_seen_in)                     ? elrsb_pkg::NET_LOOP    :
                                                              elrsb_pkg::NET_NORMAL;

    // Ring status: a new rapid-cycle event wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ring_topo_r      <= 1'b0;
            net_status_r     <= elrsb_pkg::NET_NORMAL;
            rapid_r          <= 1'b0;
            block_ring_fwd_r <= 1'b0;
        end else begin
            ring_topo_r  <= ring_mode_in;
            net_status_r <= net_nxt;
            if (rapid_cycle_evt && ring_mode_in && supervisor_in) begin
                rapid_r          <= 1'b1;
                block_ring_fwd_r <= 1'b1;
            end else if (clr_rapid) begin
                rapid_r          <= 1'b0;
                block_ring_fwd_r <= 1'b0;
            end
        end
    end

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence s_ctrl_forced(int p);
        wr_ctrl[p] && !w_ctrl[elrsb_pkg::CTL_AUTONEG];
    endsequence

    sequence s_rapid_set;
        rapid_cycle_evt && ring_mode_in && supervisor_in;
    endsequence

    chk_forced_speed: assert property (
        s_ctrl_forced(0) |=> port_speed_r[0] == $past(w_speed) && !port_autoneg_r[0])
        else $error("forced speed not applied");

    chk_medium_type: assert property (
        req_valid && cls_port && is_get && req.att == elrsb_pkg::ATT_TYPE && inst_ok
        |=> rsp_r.data[7:0] == ($past(req.inst) == 8'h03 ? 8'h01 : 8'h02))
        else $error("wrong medium type");

    chk_admin_refuse: assert property (
        port_set && req.att == elrsb_pkg::ATT_ADMIN && !adm_ok
        |=> rsp_r.status == elrsb_pkg::ST_BAD_VAL && $stable(admin_r))
        else $error("reserved admin value taken");

    chk_caps_reserved: assert property (
        rsp_valid_r && $past(cls_port && is_get && req.att == elrsb_pkg::ATT_CAPS)
        |-> rsp_r.data[31:4] == 28'h0000000)
        else $error("reserved capability bits set");

    chk_ring_rev: assert property (
        req_valid && cls_ring && req.inst == 8'h00 && (is_all || is_get) &&
        req.att == elrsb_pkg::ATT_REV |=> rsp_r.data[15:0] == 16'h0003)
        else $error("ring revision wrong");

    chk_inst_svc: assert property (
        req_valid && cls_ring && req.inst == 8'h01 && is_all
        |=> rsp_r.status == elrsb_pkg::ST_NO_SVC)
        else $error("read-all taken at instance level");

    chk_fault_gate: assert property (
        net_status_r == elrsb_pkg::NET_RFAULT |-> $past(ring_mode_in))
        else $error("ring fault outside ring mode");

    chk_loop_gate: assert property (
        net_status_r == elrsb_pkg::NET_LOOP |-> !$past(ring_mode_in))
        else $error("loop reported in ring mode");

    chk_rapid_hold: assert property (
        s_rapid_set ##1 (!clr_rapid)[*4] |=> block_ring_fwd_r)
        else $error("forwarding block dropped early");

    chk_answer_time: assert property (
        req_valid |=> rsp_valid_r ##1 (rsp_valid_r == $past(req_valid)))
        else $error("answer not one cycle after request");

endmodule

// File: dv/elrsb_client.sv
// Network client model that issues attribute services to the bank.
`timescale 1ns/1ps
module elrsb_client (
    // Clock.
    input  wire logic                  clk_sys,
    // Service request.
    output logic                       req_valid,
    output elrsb_pkg::elrsb_req_t      req,
    // Service answer.
    input  wire logic                  rsp_valid_r,
    input  wire elrsb_pkg::elrsb_rsp_t rsp_r
);
    // Request lines start idle.
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
    // One service: strobe for one cycle, then wait a bounded time for the answer.
    task automatic xfer(input logic [31:0] hdr, input logic [31:0] wd,
                        output elrsb_pkg::elrsb_rsp_t rsp, output logic ok);
        ok  = 1'b0;
        rsp = '0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req       <= {hdr, wd};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        req       <= ~{hdr, wd}; // Released lines must not keep their last value.
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rsp_valid_r === 1'b1) begin
                ok  = 1'b1;
                rsp = rsp_r;
            end else begin
                @(posedge clk_sys);
            end
        end
    endtask
endmodule

// File: dv/tb_ethernet_link_ring_status_bank.sv
// Self-checking testbench for the link and ring attribute bank.
`timescale 1ns/1ps
module tb_ethernet_link_ring_status_bank;
    // Design connections and bench counters.
    logic                  clk_sys = 1'b0;
    logic                  nrst = 1'b0;
    logic                  req_valid, rsp_valid_r, ring_topo_r, block_ring_fwd_r;
    elrsb_pkg::elrsb_req_t req;
    elrsb_pkg::elrsb_rsp_t rsp_r;
    logic                  ring_mode_in = 1'b0, supervisor_in = 1'b0, ring_fault_in = 1'b0;
    logic                  loop_seen_in = 1'b0, partial_fault_in = 1'b0, rapid_cycle_evt = 1'b0;
    logic [2:0]            port_enable_r, port_autoneg_r, port_full_duplex_r;
    logic [2:0][15:0]      port_speed_r;
    logic [7:0]            net_status_r;
    int                    error_cnt = 0;
    int                    n_checks = 0;

    // Clock at 200 MHz.
    always #2.5 clk_sys = ~clk_sys;

    // Bank and client model.
    elrsb_bank u_dut (.clk_sys(clk_sys), .nrst(nrst), .req_valid(req_valid), .req(req),
        .rsp_valid_r(rsp_valid_r), .rsp_r(rsp_r), .ring_mode_in(ring_mode_in),
        .supervisor_in(supervisor_in), .ring_fault_in(ring_fault_in),
        .loop_seen_in(loop_seen_in), .partial_fault_in(partial_fault_in),
        .rapid_cycle_evt(rapid_cycle_evt), .port_enable_r(port_enable_r),
        .port_autoneg_r(port_autoneg_r), .port_full_duplex_r(port_full_duplex_r),
        .port_speed_r(port_speed_r), .ring_topo_r(ring_topo_r),
        .net_status_r(net_status_r), .block_ring_fwd_r(block_ring_fwd_r));
    elrsb_client u_cli (.clk_sys(clk_sys), .req_valid(req_valid), .req(req),
        .rsp_valid_r(rsp_valid_r), .rsp_r(rsp_r));

    // Compares one value and reports a mismatch.
    task automatic chk(input string what, input logic [79:0] seen, input logic [79:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Runs one service and judges status and, when asked, the data.
    task automatic rq(input logic [31:0] hdr, input logic [31:0] wd, input logic [7:0] st,
                      input logic [71:0] d, input logic nd = 1'b0);
        elrsb_pkg::elrsb_rsp_t r;
        logic                  ok;
        u_cli.xfer(hdr, wd, r, ok);
        if (!ok) begin
            error_cnt++;
            finish_test();
        end else begin
            chk("status", r.status, st);
            if (st == elrsb_pkg::ST_OK && !nd) chk("data", r.data, d);
        end
    endtask

    // Port attribute read and write shorthands.
    task automatic pget(input logic [7:0] i, a, st, input logic [71:0] d);
        rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_PORT, i, a}, 32'h0, st, d);
    endtask
    task automatic pset(input logic [7:0] i, a, input logic [31:0] wd, input logic [7:0] st);
        rq({elrsb_pkg::SVC_SET_ONE, elrsb_pkg::CLS_PORT, i, a}, wd, st, 72'h0, 1'b1);
    endtask

    // Output levels while reset is held.
    task automatic t_reset();
        @(posedge clk_sys);
        #1;
        chk("enable", port_enable_r, 3'b111);
        chk("autoneg", port_autoneg_r, 3'b011);
        chk("netstat", net_status_r, elrsb_pkg::NET_NORMAL);
        chk("block", block_ring_fwd_r, 1'b0);
    endtask

    // Fixed identity attributes of all three ports, plus refused accesses.
    task automatic t_ident();
        logic ext;
        for (int i = 1; i <= 3; i++) begin
            ext = (i < 3);
            pget(8'(i), elrsb_pkg::ATT_TYPE, 8'h0, ext ? 72'h2 : 72'h1);
            pget(8'(i), elrsb_pkg::ATT_LABEL, 8'h0, i == 1 ? elrsb_pkg::LBL_P1 :
                 i == 2 ? elrsb_pkg::LBL_P2 : elrsb_pkg::LBL_INT);
            pget(8'(i), elrsb_pkg::ATT_CAPS, 8'h0,
                 72'({ext, ext, ext, ext & elrsb_pkg::CAP_RST_REQ}));
            pget(8'(i), elrsb_pkg::ATT_FLAGS, 8'h0,
                 72'({ext & elrsb_pkg::CAP_RST_REQ, 5'h0}));
            pget(8'(i), elrsb_pkg::ATT_STATE, 8'h0, 72'h1);
        end
        pget(8'h1, 8'h05, elrsb_pkg::ST_NO_ATT, 72'h0);
        pget(8'h4, elrsb_pkg::ATT_TYPE, elrsb_pkg::ST_NO_DEST, 72'h0);
        pset(8'h1, elrsb_pkg::ATT_TYPE, 32'h1, elrsb_pkg::ST_RO_ATT);
    endtask

    // Administrative disable, reserved values refused, then enable again.
    task automatic t_admin();
        pset(8'h2, elrsb_pkg::ATT_ADMIN, 32'h2, 8'h0);
        chk("enable", port_enable_r, 3'b101);
        pget(8'h2, elrsb_pkg::ATT_STATE, 8'h0, 72'h2);
        pset(8'h2, elrsb_pkg::ATT_ADMIN, 32'h3, elrsb_pkg::ST_BAD_VAL);
        pset(8'h2, elrsb_pkg::ATT_ADMIN, 32'h0, elrsb_pkg::ST_BAD_VAL);
        pget(8'h2, elrsb_pkg::ATT_ADMIN, 8'h0, 72'h2);
        pset(8'h2, elrsb_pkg::ATT_ADMIN, 32'h1, 8'h0);
        chk("enable", port_enable_r, 3'b111);
    endtask

    // Forced speed and duplex with negotiation off, conflicts and bad values.
    task automatic t_speed();
        pset(8'h2, elrsb_pkg::ATT_CTRL, {16'd100, 16'h0002}, 8'h0);
        chk("speed", port_speed_r[1], 16'd100);
        chk("autoneg", port_autoneg_r, 3'b001);
        chk("duplex", port_full_duplex_r[1], 1'b1);
        pget(8'h2, elrsb_pkg::ATT_CTRL, 8'h0, 72'({16'd100, 16'h0002}));
        pset(8'h1, elrsb_pkg::ATT_CTRL, {16'd100, 16'h0003}, elrsb_pkg::ST_CONFLICT);
        pset(8'h1, elrsb_pkg::ATT_CTRL, {16'd10, 16'h0004}, elrsb_pkg::ST_BAD_VAL);
        pset(8'h1, elrsb_pkg::ATT_CTRL, {16'd50, 16'h0000}, elrsb_pkg::ST_BAD_VAL);
        pset(8'h1, elrsb_pkg::ATT_CTRL, {16'd10, 16'h0000}, 8'h0);
        chk("speed", port_speed_r[0], 16'd10);
        pset(8'h3, elrsb_pkg::ATT_CTRL, {16'd10, 16'h0000}, elrsb_pkg::ST_NO_ATT);
        pset(8'h2, elrsb_pkg::ATT_CTRL, {16'd10, 16'h0001}, 8'h0);
        chk("speed", port_speed_r[1], 16'h0);
    endtask

    // Ring object services at class and instance level.
    task automatic t_ring();
        rq({elrsb_pkg::SVC_GET_ALL, elrsb_pkg::CLS_RING, 8'h0, 8'h1}, 0, 8'h0, 72'h3);
        rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_RING, 8'h0, 8'h1}, 0, 8'h0, 72'h3);
        rq({elrsb_pkg::SVC_SET_ONE, elrsb_pkg::CLS_RING, 8'h0, 8'h1}, 0, 8'h08, 72'h0);
        rq({elrsb_pkg::SVC_GET_ALL, elrsb_pkg::CLS_RING, 8'h1, 8'h1}, 0, 8'h08, 72'h0);
        rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_RING, 8'h2, 8'h1}, 0, 8'h05, 72'h0);
    endtask

    // Topology and network status for eight input combinations.
    task automatic t_net();
        logic [7:0] tbl [8] = '{8'h80, 8'h90, 8'ha1, 8'h20, 8'h12, 8'h88, 8'hcb, 8'h48};
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            {ring_mode_in, supervisor_in, ring_fault_in, loop_seen_in, partial_fault_in}
                <= tbl[i][7:3];
            rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_RING, 8'h1, 8'h1}, 0, 8'h0,
               72'(tbl[i][7]));
            rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_RING, 8'h1, 8'h2}, 0, 8'h0,
               72'(tbl[i][2:0]));
            chk("netstat", net_status_r, 8'(tbl[i][2:0]));
            chk("topo", ring_topo_r, tbl[i][7]);
        end
    endtask

    // Rapid fault cycles: ignored in linear, latched in ring until cleared.
    task automatic t_rapid();
        @(posedge clk_sys);
        {ring_mode_in, supervisor_in, partial_fault_in, rapid_cycle_evt} <= 4'b0001;
        @(posedge clk_sys);
        rapid_cycle_evt <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("block", block_ring_fwd_r, 1'b0);
        @(posedge clk_sys);
        {ring_mode_in, supervisor_in, rapid_cycle_evt} <= 3'b111;
        @(posedge clk_sys);
        rapid_cycle_evt <= 1'b0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk("block", block_ring_fwd_r, 1'b1);
        rq({elrsb_pkg::SVC_GET_ONE, elrsb_pkg::CLS_RING, 8'h1, 8'h2}, 0, 8'h0, 72'h4);
        rq({elrsb_pkg::SVC_CLR_RAPID, elrsb_pkg::CLS_RING, 8'h1, 8'h0}, 0, 8'h0, 72'h0, 1'b1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("block", block_ring_fwd_r, 1'b0);
        chk("netstat", net_status_r, elrsb_pkg::NET_NORMAL);
    endtask

    // Reset for two cycles, then every scenario in turn.
    initial begin
        t_reset();
        @(posedge clk_sys);
        nrst <= 1'b1;
        t_ident();
        t_admin();
        t_speed();
        t_ring();
        t_net();
        t_rapid();
        // Second reset in mid-run: outputs and settings return to their reset values.
        @(posedge clk_sys);
        nrst <= 1'b0;
        t_reset();
        @(posedge clk_sys);
        nrst <= 1'b1;
        pget(8'h1, elrsb_pkg::ATT_CTRL, 8'h0, 72'h000a_0001);
        finish_test();
    end
endmodule
